// ---- logic/bbnio_defs.vh ----
// Contract
// - Primary bus number RW bits 7:0, preloadable
// - Secondary bus number RW bits 15:8
// - Subordinate bus number RW bits 23:16
// - Forward mode latency timer RW, PCI-X 40h
// - Reverse mode latency timer reads zero
// - I/O capability nibbles read constant 1h
// - Base bits 15:12, low bits zero
// - Limit bits 15:12, low bits all ones
// - Decode 32 bits using upper register
// - Primary address inside window goes downstream
// - Limit below base forwards nothing downstream
// - Limit below base forwards everything upstream
`ifndef BBNIO_DEFS_VH
`define BBNIO_DEFS_VH
`define BBNIO_OFS_BUSNUM    8'h18
`define BBNIO_OFS_IOWIN     8'h1c
`define BBNIO_OFS_IOUPPER   8'h30
`define BBNIO_IO_CAP        4'h1
`define BBNIO_LAT_PCIX_RST  8'h40
`define BBNIO_LAT_PCI_RST   8'h00
`define BBNIO_BASE_LOW      12'h000
`define BBNIO_LIMIT_LOW     12'hfff
`define BBNIO_LAT_REV       8'h00
`define BBNIO_BUS_RST       8'h00
`define BBNIO_NIB_RST       4'h0
`define BBNIO_UP_RST        8'h00
`define BBNIO_ACK_RST       1'b0
`define BBNIO_RD_ZERO       32'h0000_0000
`define BBNIO_STAT_PAD      16'h0000
`define BBNIO_PRI_F         7:0
`define BBNIO_SEC_F         15:8
`define BBNIO_SUB_F         23:16
`define BBNIO_LAT_F         31:24
`define BBNIO_BASE_F        7:4
`define BBNIO_LIMIT_F       15:12
`define BBNIO_BUP_LO_F      7:0
`define BBNIO_BUP_HI_F      15:8
`define BBNIO_LUP_LO_F      23:16
`define BBNIO_LUP_HI_F      31:24
`define BBNIO_LANE0         0
`define BBNIO_LANE1         1
`define BBNIO_LANE2         2
`define BBNIO_LANE3         3
`endif

// ---- logic/bbnio_regs.v ----
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`include "bbnio_defs.vh"
module bbnio_field #(
   parameter W = 8
) (
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   input  wire [W-1:0] rst_val_i,
   input  wire         ld_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg  [W-1:0] val_q;
   reg  [W-1:0] val_d;
   // Holds unless loaded; reset value may depend on mode pins
   always @* begin
      val_d = val_q;
      if (ld_i) begin
         val_d = d_i;
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         val_q <= rst_val_i;
      end else if (ce_i) begin
         val_q <= val_d;
      end
   end
   assign q_o = val_q;
endmodule // bbnio_field

module bbnio_regs (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        reverse_mode_i,
   input  wire        pcix_mode_i,
   input  wire        ee_load_i,
   input  wire [7:0]  ee_addr_i,
   input  wire [31:0] ee_data_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire [31:0] pri_io_addr_i,
   input  wire [31:0] sec_io_addr_i,
   output wire        fwd_down_o,
   output wire        fwd_up_o,
   output wire        window_valid_o
);
   // Bus request decode
   wire        req;
   wire        wr;
   wire        wr_ok;
   wire        ee_bus;
   wire        ee_win;
   wire        wr_bus;
   wire        wr_win;
   wire        wr_up;
   // Field load strobes
   wire        ld_pri;
   wire        ld_sec;
   wire        ld_sub;
   wire        ld_lat;
   wire        ld_base;
   wire        ld_limit;
   wire        ld_base_lo;
   wire        ld_base_hi;
   wire        ld_limit_lo;
   wire        ld_limit_hi;
   // Field next values
   wire [7:0]  d_pri;
   wire [7:0]  d_sec;
   wire [7:0]  d_sub;
   wire [7:0]  d_lat;
   wire [3:0]  d_base;
   wire [3:0]  d_limit;
   // Field contents
   wire [7:0]  pri_bus;
   wire [7:0]  sec_bus;
   wire [7:0]  sub_bus;
   wire [7:0]  sec_lat;
   wire [3:0]  io_base;
   wire [3:0]  io_limit;
   wire [7:0]  base_up_lo;
   wire [7:0]  base_up_hi;
   wire [7:0]  limit_up_lo;
   wire [7:0]  limit_up_hi;
   // Window decode
   wire [7:0]  lat_rst;
   wire [7:0]  lat_rd;
   wire [31:0] base_addr;
   wire [31:0] limit_addr;
   wire        valid_d;
   wire        down_d;
   wire        up_d;
   reg  [31:0] rd_d;
   reg         valid_q;
   reg         down_q;
   reg         up_q;

   // Preload wins over a bus write in the same cycle
   assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr     = req & wb_we_i;
   assign wr_ok  = wr & ~ee_load_i;
   assign ee_bus = ee_load_i & (ee_addr_i == `BBNIO_OFS_BUSNUM);
   assign ee_win = ee_load_i & (ee_addr_i == `BBNIO_OFS_IOWIN);
   assign wr_bus = wr_ok & (wb_adr_i == `BBNIO_OFS_BUSNUM);
   assign wr_win = wr_ok & (wb_adr_i == `BBNIO_OFS_IOWIN);
   assign wr_up  = wr_ok & (wb_adr_i == `BBNIO_OFS_IOUPPER);

   // Byte lanes select fields; reverse mode locks the timer
   assign ld_pri      = ee_bus | (wr_bus & wb_sel_i[`BBNIO_LANE0]);
   assign ld_sec      = ee_bus | (wr_bus & wb_sel_i[`BBNIO_LANE1]);
   assign ld_sub      = ee_bus | (wr_bus & wb_sel_i[`BBNIO_LANE2]);
   assign ld_lat      = ~reverse_mode_i & (ee_bus | (wr_bus & wb_sel_i[`BBNIO_LANE3]));
   assign ld_base     = ee_win | (wr_win & wb_sel_i[`BBNIO_LANE0]);
   assign ld_limit    = ee_win | (wr_win & wb_sel_i[`BBNIO_LANE1]);
   assign ld_base_lo  = wr_up & wb_sel_i[`BBNIO_LANE0];
   assign ld_base_hi  = wr_up & wb_sel_i[`BBNIO_LANE1];
   assign ld_limit_lo = wr_up & wb_sel_i[`BBNIO_LANE2];
   assign ld_limit_hi = wr_up & wb_sel_i[`BBNIO_LANE3];

   // Preload data or bus data
   assign d_pri   = ee_bus ? ee_data_i[`BBNIO_PRI_F] : wb_dat_i[`BBNIO_PRI_F];
   assign d_sec   = ee_bus ? ee_data_i[`BBNIO_SEC_F] : wb_dat_i[`BBNIO_SEC_F];
   assign d_sub   = ee_bus ? ee_data_i[`BBNIO_SUB_F] : wb_dat_i[`BBNIO_SUB_F];
   assign d_lat   = ee_bus ? ee_data_i[`BBNIO_LAT_F] : wb_dat_i[`BBNIO_LAT_F];
   assign d_base  = ee_win ? ee_data_i[`BBNIO_BASE_F] : wb_dat_i[`BBNIO_BASE_F];
   assign d_limit = ee_win ? ee_data_i[`BBNIO_LIMIT_F] : wb_dat_i[`BBNIO_LIMIT_F];

   // Timer reset value and read view by mode
   assign lat_rst    = pcix_mode_i ? `BBNIO_LAT_PCIX_RST : `BBNIO_LAT_PCI_RST;
   assign lat_rd     = reverse_mode_i ? `BBNIO_LAT_REV : sec_lat;
   assign base_addr  = {base_up_hi, base_up_lo, io_base, `BBNIO_BASE_LOW};
   assign limit_addr = {limit_up_hi, limit_up_lo, io_limit, `BBNIO_LIMIT_LOW};

   // Inclusive window over all 32 address bits
   assign valid_d = (limit_addr >= base_addr);
   assign down_d  = valid_d & (pri_io_addr_i >= base_addr)
                    & (pri_io_addr_i <= limit_addr);
   assign up_d    = ~valid_d | (sec_io_addr_i < base_addr)
                    | (sec_io_addr_i > limit_addr);

   // Read data; unmapped offsets read as zero
   always @* begin
      case (wb_adr_i)
         `BBNIO_OFS_BUSNUM: begin
            rd_d = {lat_rd, sub_bus, sec_bus, pri_bus};
         end
         `BBNIO_OFS_IOWIN: begin
            rd_d = {`BBNIO_STAT_PAD, io_limit, `BBNIO_IO_CAP, io_base, `BBNIO_IO_CAP};
         end
         `BBNIO_OFS_IOUPPER: begin
            rd_d = {limit_up_hi, limit_up_lo, base_up_hi, base_up_lo};
         end
         default: begin
            rd_d = `BBNIO_RD_ZERO;
         end
      endcase
   end

   // One-cycle ack; read data held until the next request
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= `BBNIO_ACK_RST;
         wb_dat_o <= `BBNIO_RD_ZERO;
      end else if (ce_i) begin
         wb_ack_o <= req;
         if (req) begin
            wb_dat_o <= rd_d;
         end
      end
   end

   // Forwarding decisions are registered, one cycle behind the addresses
   always @(posedge clk_i) begin
      if (ce_i) begin
         valid_q <= valid_d;
         down_q  <= down_d;
         up_q    <= up_d;
      end
   end
   assign window_valid_o = valid_q;
   assign fwd_down_o     = down_q;
   assign fwd_up_o       = up_q;

   bbnio_field #(
      .W (8)
   ) pri_bus_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_BUS_RST),
      .ld_i      (ld_pri),
      .d_i       (d_pri),
      .q_o       (pri_bus)
   );

   bbnio_field #(
      .W (8)
   ) sec_bus_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_BUS_RST),
      .ld_i      (ld_sec),
      .d_i       (d_sec),
      .q_o       (sec_bus)
   );

   bbnio_field #(
      .W (8)
   ) sub_bus_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_BUS_RST),
      .ld_i      (ld_sub),
      .d_i       (d_sub),
      .q_o       (sub_bus)
   );

   bbnio_field #(
      .W (8)
   ) sec_lat_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (lat_rst),
      .ld_i      (ld_lat),
      .d_i       (d_lat),
      .q_o       (sec_lat)
   );

   bbnio_field #(
      .W (4)
   ) io_base_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_NIB_RST),
      .ld_i      (ld_base),
      .d_i       (d_base),
      .q_o       (io_base)
   );

   bbnio_field #(
      .W (4)
   ) io_limit_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_NIB_RST),
      .ld_i      (ld_limit),
      .d_i       (d_limit),
      .q_o       (io_limit)
   );

   bbnio_field #(
      .W (8)
   ) base_up_lo_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_UP_RST),
      .ld_i      (ld_base_lo),
      .d_i       (wb_dat_i[`BBNIO_BUP_LO_F]),
      .q_o       (base_up_lo)
   );

   bbnio_field #(
      .W (8)
   ) base_up_hi_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_UP_RST),
      .ld_i      (ld_base_hi),
      .d_i       (wb_dat_i[`BBNIO_BUP_HI_F]),
      .q_o       (base_up_hi)
   );

   bbnio_field #(
      .W (8)
   ) limit_up_lo_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_UP_RST),
      .ld_i      (ld_limit_lo),
      .d_i       (wb_dat_i[`BBNIO_LUP_LO_F]),
      .q_o       (limit_up_lo)
   );

   bbnio_field #(
      .W (8)
   ) limit_up_hi_i (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .rst_val_i (`BBNIO_UP_RST),
      .ld_i      (ld_limit_hi),
      .d_i       (wb_dat_i[`BBNIO_LUP_HI_F]),
      .q_o       (limit_up_hi)
   );
endmodule // bbnio_regs

// ---- dv/bbnio_props.sv ----
`timescale 1ns/10ps
module bbnio_props (
   input wire        clk_i, rst_i, ce_i, reverse_mode_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire [7:0]  wb_adr_i,
   input wire [31:0] wb_dat_o, pri_io_addr_i, sec_io_addr_i,
   input wire        fwd_down_o, fwd_up_o, window_valid_o);
   wire rd = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i & ~wb_we_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence ack_once; wb_ack_o ##1 !wb_ack_o; endsequence
   ack_pulse_a: assert property (rd |=> ack_once) else $error("ack");
   cap_nibble_a: assert property (rd && wb_adr_i == 8'h1c |=> wb_dat_o[11:8] == 4'h1
      && wb_dat_o[3:0] == 4'h1) else $error("cap");
   rev_latency_a: assert property (rd && reverse_mode_i && wb_adr_i == 8'h18
      |=> wb_dat_o[31:24] == 8'h00) else $error("lat");
   unmapped_zero_a: assert property (rd && !(wb_adr_i inside {8'h18, 8'h1c, 8'h30})
      |=> wb_dat_o == 32'h0) else $error("unmapped");
   data_hold_a: assert property (!wb_cyc_i |=> $stable(wb_dat_o)) else $error("hold");
   no_down_a: assert property (!window_valid_o |-> !fwd_down_o) else $error("down");
   all_up_a: assert property (!window_valid_o |-> fwd_up_o) else $error("up");
   one_way_a: assert property (window_valid_o && $past(ce_i)
      && $past(pri_io_addr_i) == $past(sec_io_addr_i)
      |-> fwd_down_o ^ fwd_up_o) else $error("dir");
endmodule // bbnio_props
bind bbnio_regs bbnio_props bbnio_props_i (.*);

// ---- dv/bridge_bus_number_io_window_tb_top.sv ----
`timescale 1ns/10ps
module bridge_bus_number_io_window_tb_top;
   logic clk_i = 0, rst_i = 1, ce_i = 1, reverse_mode_i = 0, pcix_mode_i = 0, ee_load_i = 0;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, fwd_down_o, fwd_up_o, window_valid_o;
   logic [7:0] ee_addr_i = '0, wb_adr_i = '0;
   logic [3:0] wb_sel_i = '0;
   logic [31:0] ee_data_i = '0, wb_dat_i = '0, wb_dat_o, pri_io_addr_i = '0, sec_io_addr_i = '0;
   int fail_count = 0, n_tests = 0;
   always #5 clk_i = ~clk_i;
   bbnio_regs bbnio_regs_i (.*);
   task automatic chk(input logic [31:0] s, e);
      n_tests++;
      if (s !== e) $display("MISMATCH %0t %h /= %h", $time, s, e);
      fail_count += (s !== e);
   endtask
   task automatic finish_test;
      $display("%0d checks, %0d mismatches", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
      int n = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
      if (n == 20) begin fail_count++; finish_test; end
      if (!w) chk(wb_dat_o, e);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
   endtask
   task automatic io(input logic [31:0] p, s, input logic [2:0] e);
      {pri_io_addr_i, sec_io_addr_i} <= {p, s};
      repeat (2) @(posedge clk_i);
      chk({window_valid_o, fwd_down_o, fwd_up_o}, e);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, 8'h18, '0, '0);
      bus(0, 8'h1c, '0, 32'h0101);
      bus(1, 8'h18, 32'h55201003, '0);
      bus(0, 8'h18, '0, 32'h55201003);
      bus(0, 8'h20, '0, '0);
      reverse_mode_i <= 1'b1;
      bus(1, 8'h18, 32'haa201003, '0);
      bus(0, 8'h18, '0, 32'h00201003);
      {ee_load_i, ee_addr_i, ee_data_i} <= {9'h118, 32'h77030201};
      @(posedge clk_i);
      ee_load_i <= 1'b0;
      reverse_mode_i <= 1'b0;
      bus(0, 8'h18, '0, 32'h55030201);
      {ce_i, ee_load_i, ee_addr_i, ee_data_i} <= {10'h11c, 32'h0000f0f0};
      @(posedge clk_i);
      {ce_i, ee_load_i} <= 2'b10;
      bus(0, 8'h1c, '0, 32'h0101);
      {ee_load_i, ee_addr_i, ee_data_i} <= {9'h11c, 32'h00005040};
      @(posedge clk_i);
      ee_load_i <= 1'b0;
      bus(0, 8'h1c, '0, 32'h5141);
      bus(1, 8'h1c, 32'h3020, '0);
      bus(1, 8'h30, 32'h00010001, '0);
      bus(0, 8'h30, '0, 32'h00010001);
      io(32'h00012000, 32'h00012000, 3'b110);
      io(32'h00011fff, 32'h00011fff, 3'b101);
      io(32'h00013fff, 32'h00014000, 3'b111);
      io(32'h00002000, 32'h00013000, 3'b100);
      bus(1, 8'h1c, 32'h3040, '0);
      io(32'h00013000, 32'h00013000, 3'b001);
      {rst_i, pcix_mode_i} <= 2'b11;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, 8'h18, '0, 32'h40000000);
      bus(0, 8'h30, '0, '0);
      io(32'h00000800, 32'h00001000, 3'b111);
      finish_test;
   end
endmodule // bridge_bus_number_io_window_tb_top
